/* common/sar_seq_regs.svh */
`ifndef SAR_SEQ_REGS_SVH
`define SAR_SEQ_REGS_SVH
// result width and conversion step count
`define SAR_RES_W      8
`define SAR_STEPS      8
// all-zero code and all-ones code
`define SAR_CODE_ZERO  8'h00
`define SAR_CODE_FULL  8'hff
// code of half scale, first trial bit
`define SAR_TRIAL_MSB  8'h80
// clock divider for the internal oscillator option (mclk cycles per half period)
`define SAR_OSC_HALF   4'h8
// divider counter: width, start, increment and last count of a half period
`define SAR_OSC_CNT_W  4
`define SAR_OSC_ZERO   4'h0
`define SAR_OSC_ONE    4'h1
`define SAR_OSC_LAST   4'h7
// position of the last trial bit and the step shift per decision
`define SAR_LSB_POS    0
`define SAR_STEP_SHIFT 1
// flag levels and the reset value of the external clock edge detector
`define SAR_FLAG_CLR   1'b0
`define SAR_FLAG_SET   1'b1
`define SAR_EXT_PREV_RST 1'b1
`endif

/* common/sar_seq_pkg.sv */
package sar_seq_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_HOLD,
        ST_CONV,
        ST_DONE
    } seq_state_e;
endpackage

/* src/sar_result_latch.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sar_seq_regs.svh"
module sar_result_latch #(
    parameter int W = `SAR_RES_W
) (
    // clock and reset
    input  wire logic         mclk_i,
    input  wire logic         rst_n_i,
    // load side
    input  wire logic         load_i,
    input  wire logic [W-1:0] word_i,
    // held result
    output logic      [W-1:0] word_o
);
    logic [W-1:0] word_r;

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            word_r <= W'(`SAR_CODE_ZERO);
        end else if (load_i) begin
            word_r <= word_i;
        end
    end

    assign word_o = word_r;
endmodule // sar_result_latch
`default_nettype wire

/* src/sar_conversion_sequencer.sv */
// Behaviour
// - restart mid-conversion aborts and starts fresh
// - aborted conversion never loads output latch
// - clock from external source or oscillator
// - unsigned code, zero input gives zeros
// - straight binary, code = vin/fs*256
// - held reset while select and start low
// - latch word, done asserts one clock later
// - select and read drive data, clear done
`timescale 1ns/1ps
`default_nettype none
`include "sar_seq_regs.svh"
module sar_conversion_sequencer #(
    parameter int W = `SAR_RES_W
) (
    // clock and reset
    input  wire logic         mclk_i,
    input  wire logic         rst_n_i,
    // clock source choice: 1 = internal divider, 0 = external clock edges
    input  wire logic         use_osc_i,
    input  wire logic         ext_clk_i,
    output logic              osc_drive_o,
    // control strobes, active low
    input  wire logic         sel_n_i,
    input  wire logic         start_n_i,
    input  wire logic         read_n_i,
    // comparator: high when input is at or above trial code
    input  wire logic         cmp_above_i,
    output logic      [W-1:0] trial_code_o,
    // result bus, two signals per bit
    output logic      [W-1:0] data_o,
    output logic      [W-1:0] data_oe_n_o,
    // completion
    output logic              conv_done_n_o
);
    // state and sequencing
    sar_seq_pkg::seq_state_e   state_r;
    sar_seq_pkg::seq_state_e   state_nxt;

    // conversion clock generation
    logic [`SAR_OSC_CNT_W-1:0] div_cnt_r;
    logic [`SAR_OSC_CNT_W-1:0] div_cnt_nxt;
    logic                      div_wrap;
    logic                      osc_r;
    logic                      osc_nxt;
    logic                      osc_tick;
    logic                      ext_prev_r;
    logic                      ext_prev_nxt;
    logic                      ext_tick;
    logic                      step_tick;

    // control decode
    logic                      start_req;
    logic                      read_req;
    logic                      in_hold;
    logic                      in_conv;
    logic                      in_done;
    logic                      sar_clear;
    logic                      conv_step;
    logic                      conv_last;

    // approximation register
    logic [W-1:0]              step_r;
    logic [W-1:0]              step_nxt;
    logic [W-1:0]              step_shift;
    logic [W-1:0]              trial_r;
    logic [W-1:0]              trial_nxt;
    wire logic [W-1:0]         trial_dec;

    // completion flag
    logic                      done_r;
    logic                      done_nxt;
    logic                      done_set;
    logic                      done_clr;

    // latch load
    logic                      latch_load;
    logic [W-1:0]              latch_word;

    // a divider stands in for the rc network, so the conversion rate is
    // fixed by the divider count rather than by outside parts
    assign div_wrap    = (div_cnt_r == `SAR_OSC_LAST);
    assign div_cnt_nxt = div_wrap ? `SAR_OSC_ZERO : div_cnt_r + `SAR_OSC_ONE;
    assign osc_nxt     = div_wrap ? ~osc_r : osc_r;
    // one step per full oscillator period, on its rising phase
    assign osc_tick    = div_wrap & ~osc_r;

    // the external clock is sampled, so it must run below half of mclk
    assign ext_prev_nxt = ext_clk_i;
    assign ext_tick     = ext_clk_i & ~ext_prev_r;
    assign step_tick    = use_osc_i ? osc_tick : ext_tick;
    assign osc_drive_o  = osc_r;

    // request decode
    assign start_req = ~sel_n_i & ~start_n_i;
    assign read_req  = ~sel_n_i & ~read_n_i;
    assign in_hold   = (state_r == sar_seq_pkg::ST_HOLD);
    assign in_conv   = (state_r == sar_seq_pkg::ST_CONV);
    assign in_done   = (state_r == sar_seq_pkg::ST_DONE);

    // while the request stands the register is held at its first trial
    assign sar_clear = start_req | in_hold;
    assign conv_step = in_conv & step_tick & ~start_req;
    assign conv_last = conv_step & step_r[`SAR_LSB_POS];

    // next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            sar_seq_pkg::ST_IDLE: begin
                if (start_req) begin
                    state_nxt = sar_seq_pkg::ST_HOLD;
                end
            end
            sar_seq_pkg::ST_HOLD: begin
                if (!start_req) begin
                    state_nxt = sar_seq_pkg::ST_CONV;
                end
            end
            sar_seq_pkg::ST_CONV: begin
                if (start_req) begin
                    state_nxt = sar_seq_pkg::ST_HOLD;
                end else if (conv_last) begin
                    state_nxt = sar_seq_pkg::ST_DONE;
                end
            end
            sar_seq_pkg::ST_DONE: begin
                if (start_req) begin
                    state_nxt = sar_seq_pkg::ST_HOLD;
                end else begin
                    state_nxt = sar_seq_pkg::ST_IDLE;
                end
            end
            default: begin
                state_nxt = sar_seq_pkg::ST_IDLE;
            end
        endcase
    end

    // per bit: decide the bit under trial, raise the trial on the one below
    generate
        for (genvar b = 0; b < W; b++) begin : g_bit
            if (b == W - 1) begin : g_top
                assign trial_dec[b] = step_r[b] ? cmp_above_i : trial_r[b];
            end else begin : g_low
                assign trial_dec[b] = step_r[b]     ? cmp_above_i :
                                      step_r[b + 1] ? `SAR_FLAG_SET : trial_r[b];
            end
        end
    endgenerate

    assign step_shift = step_r >> `SAR_STEP_SHIFT;

    always_comb begin
        step_nxt  = step_r;
        trial_nxt = trial_r;
        if (sar_clear) begin
            step_nxt  = W'(`SAR_TRIAL_MSB);
            trial_nxt = W'(`SAR_TRIAL_MSB);
        end else if (conv_step) begin
            step_nxt  = step_shift;
            trial_nxt = trial_dec;
        end
    end

    assign trial_code_o = trial_r;

    // the latch takes the word only on the last step of an unbroken run
    assign latch_load = conv_last;
    assign latch_word = trial_dec;

    // done: a set and a clear in one cycle leave the flag set
    assign done_set = in_done & ~start_req;
    assign done_clr = start_req | read_req;
    assign done_nxt = done_set ? `SAR_FLAG_SET : (done_clr ? `SAR_FLAG_CLR : done_r);
    // done falls one clock after the latch has taken the word
    assign conv_done_n_o = ~done_r;

    // output buffers enabled for the whole read strobe
    assign data_oe_n_o = {W{~read_req}};

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            state_r <= sar_seq_pkg::ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            div_cnt_r <= `SAR_OSC_ZERO;
        end else begin
            div_cnt_r <= div_cnt_nxt;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            osc_r <= `SAR_FLAG_CLR;
        end else begin
            osc_r <= osc_nxt;
        end
    end

    // reset high so that a pin already high gives no false edge
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            ext_prev_r <= `SAR_EXT_PREV_RST;
        end else begin
            ext_prev_r <= ext_prev_nxt;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            step_r <= W'(`SAR_CODE_ZERO);
        end else begin
            step_r <= step_nxt;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            trial_r <= W'(`SAR_CODE_ZERO);
        end else begin
            trial_r <= trial_nxt;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            done_r <= `SAR_FLAG_CLR;
        end else begin
            done_r <= done_nxt;
        end
    end

    // held result, kept across aborted conversions
    sar_result_latch #(
        .W       (W)
    ) sar_result_latch_inst (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .load_i  (latch_load),
        .word_i  (latch_word),
        .word_o  (data_o)
    );
endmodule // sar_conversion_sequencer
`default_nettype wire

/* verif/sar_cmp_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sar_cmp_model(
    // analog side
    input  wire logic [7:0] vin_i,
    input  wire logic [7:0] trial_i,
    output logic            above_o,
    // start glue
    input  wire logic       free_run_i,
    input  wire logic       kick_n_i,
    input  wire logic       start_drv_i,
    input  wire logic       done_n_i,
    output logic            start_n_o
);
    assign above_o   = vin_i >= trial_i;
    // free-running: start tied to done, kicked low once after power-up
    assign start_n_o = free_run_i ? (done_n_i & kick_n_i) : start_drv_i;
endmodule // sar_cmp_model
`default_nettype wire

/* verif/sar_seq_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module sar_seq_chk (
    // clock and reset
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    // strobes
    input  wire logic       sel_n_i,
    input  wire logic       start_n_i,
    input  wire logic       read_n_i,
    // outputs watched
    input  wire logic       conv_done_n_o,
    input  wire logic [7:0] data_oe_n_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_start;
        !sel_n_i && !start_n_i;
    endsequence
    sequence s_start_pulse;
        s_start ##1 (sel_n_i || start_n_i);
    endsequence
    sequence s_read;
        !sel_n_i && !read_n_i;
    endsequence
    // low for two cycles: not a set of this very cycle
    sequence s_done_settled;
        !conv_done_n_o && $past(!conv_done_n_o);
    endsequence
    a_read_drives_bus: assert property (s_read |-> ##[0:2] data_oe_n_o == 8'h00) else $error("bus idle");
    a_idle_bus_off: assert property (sel_n_i [*3] |-> data_oe_n_o == 8'hff) else $error("bus driven");
    a_start_clears_done: assert property (s_start |-> ##[0:2] conv_done_n_o) else $error("done kept");
    a_hold_keeps_done: assert property (s_start |=> conv_done_n_o) else $error("done in hold");
    a_done_holds_low: assert property ($fell(conv_done_n_o) && sel_n_i |=> !conv_done_n_o) else $error("done lost");
    a_read_clears_done: assert property (s_done_settled ##0 s_read |=> conv_done_n_o) else $error("done not cleared");
    a_no_early_done: assert property (s_start_pulse |-> conv_done_n_o [*8]) else $error("done too early");
endmodule // sar_seq_chk
bind sar_conversion_sequencer sar_seq_chk sar_seq_chk_inst(.*);
`default_nettype wire

/* verif/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sar_seq_regs.svh"
module testbench;
    logic       mclk_i = 0, rst_n_i = 0, sel_n_i = 1, start_drv = 1, read_n_i = 1;
    logic       use_osc = 1, ext_clk = 0, free_run = 0, kick_n = 1;
    logic       above, done_n, osc, prev, start_node;
    logic [7:0] vin = 0, last_done = 0, trial, data, oe_n, q[$];
    logic [1:0] ext_cnt = 0;
    int         failures = 0, comparisons = 0, seed = 7193, i, n, falls;
    initial forever #12.5 mclk_i = ~mclk_i;
    // external conversion clock, six mclk cycles a period
    always @(posedge mclk_i) begin
        #2;
        if (ext_cnt == 2'h2) begin
            ext_cnt = 2'h0;
            ext_clk = ~ext_clk;
        end else begin
            ext_cnt = ext_cnt + 2'h1;
        end
    end
    sar_conversion_sequencer sar_conversion_sequencer_inst(.mclk_i, .rst_n_i,
        .use_osc_i(use_osc), .ext_clk_i(ext_clk), .osc_drive_o(osc), .sel_n_i,
        .start_n_i(start_node), .read_n_i, .cmp_above_i(above), .trial_code_o(trial),
        .data_o(data), .data_oe_n_o(oe_n), .conv_done_n_o(done_n));
    sar_cmp_model sar_cmp_model_inst(.vin_i(vin), .trial_i(trial), .above_o(above),
        .free_run_i(free_run), .kick_n_i(kick_n), .start_drv_i(start_drv),
        .done_n_i(done_n), .start_n_o(start_node));
    task print_verdict;
        $display("%0d bad of %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check_data(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp || oe_n !== 8'h00) begin
            failures++;
            $display("BAD %0t data %h want %h", $time, got, exp);
        end
    endtask
    task automatic check_count(input int got, input int exp);
        comparisons++;
        if (got != exp) begin
            failures++;
            $display("BAD %0t count %0d want %0d", $time, got, exp);
        end
    endtask
    task cyc(int k);
        repeat (k) @(posedge mclk_i);
        #2;
    endtask
    task go(logic [7:0] v);
        vin = v;
        sel_n_i = 0;
        start_drv = 0;
        cyc(2);
        sel_n_i = 1;
        start_drv = 1;
    endtask
    task rd(logic [7:0] e);
        q.push_back(e);
        sel_n_i = 0;
        read_n_i = 0;
        cyc(2);
        sel_n_i = 1;
        read_n_i = 1;
        cyc(1);
    endtask
    task fin;
        for (i = 0; i < 5000 && done_n !== 1'b0; i++) cyc(1);
        if (done_n !== 1'b0) begin
            failures++;
            $display("BAD %0t no completion", $time);
            print_verdict;
        end
        last_done = vin;
    endtask
    task automatic wait_rise(output int c);
        c = 1;
        prev = osc;
        cyc(1);
        while (!(osc === 1'b1 && prev === 1'b0) && c < 100) begin
            prev = osc;
            cyc(1);
            c++;
        end
    endtask
    always @(negedge oe_n[0]) begin
        @(posedge mclk_i);
        #1;
        check_data(data, q.pop_front());
    end
    initial begin
        cyc(10);
        rst_n_i = 1;
        go(8'h00);
        fin;
        rd(8'h00);
        go(8'hff);
        fin;
        rd(8'hff);
        $display("test end codes done");
        repeat (3) begin
            go(8'($random(seed)));
            fin;
            rd(vin);
        end
        $display("test random codes done");
        wait_rise(n);
        wait_rise(n);
        check_count(n, 2 * `SAR_OSC_HALF);
        use_osc = 0;
        go(8'($random(seed)));
        fin;
        rd(vin);
        use_osc = 1;
        $display("test clock sources done");
        go(8'($random(seed)));
        cyc(5);
        go(8'h3c);
        rd(last_done);
        fin;
        rd(8'h3c);
        $display("test restart done");
        sel_n_i = 0;
        free_run = 1;
        vin = 8'($random(seed));
        kick_n = 0;
        cyc(2);
        kick_n = 1;
        falls = 0;
        prev = 1'b1;
        for (i = 0; i < 3000 && falls < 3; i++) begin
            cyc(1);
            if (prev === 1'b1 && done_n === 1'b0) falls++;
            prev = done_n;
        end
        check_count(falls, 3);
        free_run = 0;
        sel_n_i = 1;
        fin;
        rd(vin);
        $display("test free run done");
        print_verdict;
    end
endmodule // testbench
`default_nettype wire
